/* include/readout_pkg.sv */
// Purpose: constants for the converter result readout port
// Assumes: 40 MHz mclk, single clock domain
// Notes: all figures named once here
package readout_pkg;
    localparam int unsigned clk_mhz = 40;
    localparam int unsigned powerup_us = 10;
    localparam int unsigned powerup_cycles = powerup_us * clk_mhz;
    localparam int unsigned result_w = 14;
    localparam int unsigned word_w = 16;
    localparam int unsigned byte_w = 8;
    localparam int unsigned pad_w = word_w - result_w;
    localparam logic [13:0] result_rst = 14'h0000;
    localparam logic [13:0] sign_flip = 14'h2000;
    localparam logic [8:0] powerup_cnt_w9 = 9'(powerup_cycles);
endpackage

/* include/result_if.sv */
// Purpose: carries the latched result word between core and byte mux
// Assumes: single clock domain
// Notes: word is already coded and left-justified
interface result_if;
    logic [15:0] word;
    logic byte_high;
    logic [7:0] byte_out;
    modport core (output word, output byte_high, input byte_out);
    modport mux (input word, input byte_high, output byte_out);
endinterface

/* rtl/byte_mux.sv */
// Purpose: picks the high or low byte of the result word
// Assumes: word left-justified, low two bits zero
// Notes: purely combinational
module byte_mux (
    // word and select
    result_if.mux rif
);
    // low select gives bits 15:8, high gives 7:0
    always_comb begin
        if (rif.byte_high) begin
            rif.byte_out = rif.word[7:0];
        end else begin
            rif.byte_out = rif.word[15:8];
        end
    end
endmodule

/* rtl/result_readout_port.sv */
// Purpose: converter result readout, done status and power-up reset
// Assumes: host pins synchronous to mclk; core supplies result and busy
// Notes: done pin is two signals; pull-up is outside in async mode
module result_readout_port (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // conversion core side
    input wire logic conv_busy,
    input wire logic conv_done_pulse,
    input wire logic [13:0] conv_result,
    // mode straps
    input wire logic sync_mode,
    input wire logic range_offset_strap,
    // host control pins
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic byte_select_high,
    input wire logic done_flag_enable_n,
    // result bus
    output logic [7:0] result_byte_bus_o,
    output logic result_byte_bus_oe,
    // done status pin
    output logic done_o,
    output logic done_oe,
    // ready after power-up reset
    output logic logic_ready
);
    // read walk, one mclk per step:
    //   c0 core pulses done and the coded word is latched
    //   c1 host lowers chip select and output enable, byte select low
    //   c2 high byte stands on the pins from its flop
    //   c2 host raises byte select
    //   c3 low byte stands on the pins
    // the pins lag the select by one cycle; a host that samples on the
    // same edge it moves the select would take the other byte

    // done pin by mode:
    //   sync, chip select and enable low: driven, low while busy
    //   sync, otherwise: released
    //   async, enable low and busy: pulled low
    //   async, otherwise: released to the outside pull-up

    // every flop holds while clk_en is low; the pin enables still follow
    // the host selects, so a frozen block keeps its pins under host control

    // one-hot codes so one flop names the phase
    typedef enum logic [1:0] {
        st_reset = 2'b01,
        st_run = 2'b10
    } state_t;

    // power-up sequencer
    state_t state_q;
    state_t state_d;
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;

    // stored result word, coded and left-justified
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic take_result;

    // byte shown on the result pins
    logic [7:0] bus_q;
    logic [7:0] bus_d;

    // done status, one cycle behind busy
    logic done_q;
    logic done_d;

    // pin enable terms
    logic bus_en;
    logic done_sync_en;
    logic done_async_en;

    // word and select to the byte picker
    result_if rif ();

    // true once the power-up wait has run out
    function automatic logic is_running(state_t s);
        is_running = (s == st_run);
    endfunction

    // bipolar flips the sign bit of the core's offset-binary code
    function automatic logic [13:0] code_result(logic [13:0] raw, logic bipolar);
        if (bipolar) begin
            code_result = raw ^ readout_pkg::sign_flip;
        end else begin
            code_result = raw;
        end
    endfunction

    // 14-bit code at the top of the word, pad bits zero below it
    function automatic logic [15:0] justify(logic [13:0] code);
        justify = {code, {readout_pkg::pad_w{1'b0}}};
    endfunction

    // byte picker is combinational; the flop after it times the pins
    byte_mux u_mux (
        .rif(rif)
    );

    // select goes straight to the picker, stored word feeds it
    assign rif.word = word_q;
    assign rif.byte_high = byte_select_high;

    // power-up logic reset: count enabled cycles, then run for good
    // the wait stretches when clk_en is low; the host should watch
    // logic_ready rather than time the wait on its own
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            st_reset: begin
                if (cnt_q == readout_pkg::powerup_cnt_w9 - 9'h001) begin
                    state_d = st_run;
                end else begin
                    cnt_d = cnt_q + 9'h001;
                end
            end
            st_run: begin
                state_d = st_run;
            end
            default: begin
                // an illegal code restarts the whole wait, never shortens it
                state_d = st_reset;
                cnt_d = 9'h000;
            end
        endcase
    end

    // sequencer flops; reset restarts the whole wait
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= st_reset;
            cnt_q <= 9'h000;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // conversions ending inside the power-up wait are dropped
    assign take_result = is_running(state_q) & conv_done_pulse;

    // code and justify a finished result
    always_comb begin
        word_d = word_q;
        if (take_result) begin
            word_d = justify(code_result(conv_result, range_offset_strap));
        end
    end

    // word holds until the next finished conversion, so a read while
    // busy returns the previous result; the host has to avoid that
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            word_q <= {readout_pkg::result_rst, 2'b00};
        end else if (clk_en) begin
            word_q <= word_d;
        end
    end

    // next pin byte follows the picker
    always_comb begin
        bus_d = rif.byte_out;
    end

    // pins come straight from a flop, free of decode glitches
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_q <= 8'h00;
        end else if (clk_en) begin
            bus_q <= bus_d;
        end
    end

    // busy counts as converting until the power-up wait is over
    always_comb begin
        done_d = ~conv_busy & is_running(state_q);
    end

    // done status flop; low from reset so async mode pulls the pin
    // until the power-up wait is over
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= done_d;
        end
    end

    // result bus: either select high releases it
    assign bus_en = ~(chip_select_n | output_enable_n);
    assign result_byte_bus_oe = bus_en;
    // one cycle behind the select; host allows access time
    assign result_byte_bus_o = bus_q;
    // ready is a decode of the sequencer flop, so it is glitch-free
    assign logic_ready = is_running(state_q);

    // done enables for the two modes
    assign done_sync_en = ~chip_select_n & ~done_flag_enable_n;
    assign done_async_en = ~done_flag_enable_n & ~done_q;

    // done pin: three-state in sync mode, open drain in async mode
    always_comb begin
        if (sync_mode) begin
            done_oe = done_sync_en;
            done_o = done_q;
        end else begin
            // only ever drive low; the outside pull-up gives the high level
            done_oe = done_async_en;
            done_o = 1'b0;
        end
    end
endmodule

/* bench/readout_checker.sv */
// Purpose: port checks of the readout block
// Assumes: one mclk domain
// Notes: ready window exact to the cycle
module readout_checker (
    // clock, reset and enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // core side
    input wire logic conv_busy,
    input wire logic conv_done_pulse,
    input wire logic [13:0] conv_result,
    // straps
    input wire logic sync_mode,
    input wire logic range_offset_strap,
    // host pins
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic byte_select_high,
    input wire logic done_flag_enable_n,
    // outputs
    input wire logic [7:0] result_byte_bus_o,
    input wire logic result_byte_bus_oe,
    input wire logic done_o,
    input wire logic done_oe,
    input wire logic logic_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [8:0] cnt_q;
    // enabled cycles since reset, saturates so it never wraps
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) cnt_q <= 9'h000;
        else if (clk_en && cnt_q != 9'h1FF) cnt_q <= cnt_q + 9'h001;
    end
    sequence s_take; conv_done_pulse && logic_ready && clk_en; endsequence
    sequence s_hold(bit b); clk_en && !conv_done_pulse && byte_select_high == b; endsequence
    property p_high; s_take ##1 s_hold(1'b0)
        |=> result_byte_bus_o == ($past(conv_result[13:6], 2) ^ {$past(range_offset_strap, 2), 7'h00}); endproperty
    property p_pad; s_hold(1'b1) |=> result_byte_bus_o[1:0] == 2'h0; endproperty
    property p_bus_en; result_byte_bus_oe == !(chip_select_n || output_enable_n); endproperty
    property p_early; cnt_q < readout_pkg::powerup_cnt_w9 |-> !logic_ready; endproperty
    property p_late; cnt_q >= readout_pkg::powerup_cnt_w9 |-> logic_ready; endproperty
    property p_sync_oe; sync_mode |-> done_oe == (!chip_select_n && !done_flag_enable_n); endproperty
    property p_done; logic_ready && clk_en |=> done_o == (sync_mode && !$past(conv_busy)); endproperty
    property p_async_oe; !sync_mode && logic_ready && clk_en ##1 !sync_mode
        |-> done_oe == (!done_flag_enable_n && $past(conv_busy)); endproperty
    a_high: assert property (p_high) else $error("high byte wrong");
    a_pad: assert property (p_pad) else $error("pad bits not zero");
    a_bus_en: assert property (p_bus_en) else $error("bus enable wrong");
    a_early: assert property (p_early) else $error("ready too early");
    a_late: assert property (p_late) else $error("ready too late");
    a_sync_oe: assert property (p_sync_oe) else $error("sync done enable wrong");
    a_done: assert property (p_done) else $error("done level wrong");
    a_async_oe: assert property (p_async_oe) else $error("async done enable wrong");
endmodule
bind result_readout_port readout_checker readout_checker_i (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .conv_busy(conv_busy),
    .conv_done_pulse(conv_done_pulse),
    .conv_result(conv_result),
    .sync_mode(sync_mode),
    .range_offset_strap(range_offset_strap),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .byte_select_high(byte_select_high),
    .done_flag_enable_n(done_flag_enable_n),
    .result_byte_bus_o(result_byte_bus_o),
    .result_byte_bus_oe(result_byte_bus_oe),
    .done_o(done_o),
    .done_oe(done_oe),
    .logic_ready(logic_ready)
);

/* bench/host_model.sv */
// Purpose: host reading one word as two bytes
// Assumes: pins launched at the rising edge
// Notes: fixed read, high byte first
module host_model (
    // clock and request
    input wire logic mclk,
    input wire logic go,
    // result bus as the host sees it
    input wire logic [7:0] bus,
    // host pins
    output logic cs_n,
    output logic oe_n,
    output logic bsh,
    // word read back
    output logic [15:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_q = 3'h0;
    // bytes taken two cycles after the select moves, as the mux is registered
    always @(posedge mclk) begin
        if (go || ph_q != 3'h0) ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
        cs_n <= ph_q == 3'h5 || (ph_q == 3'h0 && !go);
        oe_n <= !(ph_q inside {3'h1, 3'h2, 3'h3, 3'h4});
        bsh <= ph_q == 3'h3 || ph_q == 3'h4;
        if (ph_q == 3'h3) word[15:8] <= bus;
        if (ph_q == 3'h5) word[7:0] <= bus;
    end
endmodule

/* bench/result_readout_port_tb.sv */
// Purpose: scenarios for the readout block
// Assumes: host model reads only after done
// Notes: released bus shows inverted data
module result_readout_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rstn = 0, clk_en = 1, busy = 0, pulse = 0, sync = 1, bip = 0, den_n = 0, go = 0;
    logic [13:0] res = 14'h0000;
    logic cs_n, oe_n, bsh, bus_oe, done, done_oe, rdy;
    logic [7:0] bus_o, bus;
    logic [15:0] word;
    int error_cnt = 0, checks = 0, cyc = 0;
    // stale data on a released bus must never match
    assign bus = bus_oe ? bus_o : ~bus_o;
    result_readout_port result_readout_port_i (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .conv_busy(busy),
        .conv_done_pulse(pulse), .conv_result(res), .sync_mode(sync), .range_offset_strap(bip),
        .chip_select_n(cs_n), .output_enable_n(oe_n), .byte_select_high(bsh), .done_flag_enable_n(den_n),
        .result_byte_bus_o(bus_o), .result_byte_bus_oe(bus_oe), .done_o(done), .done_oe(done_oe), .logic_ready(rdy));
    host_model host_model_i (.mclk(mclk), .go(go), .bus(bus), .cs_n(cs_n), .oe_n(oe_n), .bsh(bsh), .word(word));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc > 3000) begin error_cnt++; summarize(); end
    task summarize;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(string n, logic [15:0] e, logic [15:0] s);
        checks++;
        if (s !== e) begin error_cnt++; $display("wrong value %s expected %h seen %h", n, e, s); end
    endtask
    task conv(logic [13:0] r, logic [15:0] e);
        busy <= 1;
        repeat (4) @(posedge mclk);
        res <= r;
        pulse <= 1;
        busy <= 0;
        @(posedge mclk);
        pulse <= 0;
        go <= 1;
        @(posedge mclk);
        go <= 0;
        repeat (8) @(posedge mclk);
        chk("word", e, word);
    endtask
    task t_power;
        repeat (readout_pkg::powerup_cycles - 1) @(posedge mclk);
        @(negedge mclk);
        chk("ready early", 16'h0000, 16'(rdy));
        @(negedge mclk);
        chk("ready", 16'h0001, 16'(rdy));
        @(posedge mclk);
    endtask
    task t_freeze;
        clk_en <= 1'b0;
        res <= 14'h1234;
        pulse <= 1'b1;
        repeat (2) @(posedge mclk);
        pulse <= 1'b0;
        clk_en <= 1'b1;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("frozen word", 16'hFFFC, word);
    endtask
    task t_bipolar;
        bip <= 1;
        conv(14'h2000, 16'h0000);
        conv(14'h1FFF, 16'hFFFC);
        bip <= 0;
    endtask
    task t_status;
        chk("sync enable", 16'h0000, 16'(done_oe));
        sync <= 0;
        busy <= 1;
        repeat (3) @(posedge mclk);
        chk("async enable", 16'h0001, 16'(done_oe));
        chk("async level", 16'h0000, 16'(done));
        busy <= 0;
        den_n <= 1;
        repeat (3) @(posedge mclk);
        chk("async off", 16'h0000, 16'(done_oe));
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1;
        t_power;
        conv(14'h3FFF, 16'hFFFC);
        conv(14'h2A5B, 16'hA96C);
        t_bipolar;
        t_freeze;
        t_status;
        summarize;
    end
endmodule
